// *** core/hscp_core.sv ***
// host side control: register bank, manual poll engine, interrupt source, power and clock modes
// assumes a serial control front end decoding register accesses synchronous to clk_in,
// and a barrier link that answers an index read with one data strobe
//
// Contract
// [RULE_01] host registers 0x00-0x10 and 0x20-0x24, line copies at 0x12-0x1f; the 5-bit address here reaches 0x00-0x1f only
// [RULE_02] poll index is offset from 0x12; only 0x0 to 0x6 are pollable
// [RULE_03] setting poll request issues a barrier read of the indexed register
// [RULE_04] returned value lands in poll value register, zero after reset
// [RULE_05] match flag set when returned value equals shadow, else cleared, reset zero
// [RULE_06] poll request stays high during poll, device clears it when results ready
// [RULE_07] software reads results only after poll request clears, about 600 us
// [RULE_08] software should write poll index back to zero after a poll
// [RULE_09] fixed read-only host revision in low nibble of 0x04
// [RULE_10] line revision shows code when barrier synced, else 0000
// [RULE_11] active-low interrupt is OR of all enabled sources
// [RULE_12] general pins set as outputs never raise the interrupt
// [RULE_13] reading interrupt source register interrupt_source clears it
// [RULE_14] interrupt source resets to 0xe0 with documented bit layout
// [RULE_15] software treats interrupts during wake-on-ring as valid ring
// [RULE_16] clearing front-end enable disables barrier and line side only
// [RULE_17] sleep stops pll, selects bit clock, tri-states transmit and slot outputs
// [RULE_18] power down shuts device; registers keep contents and stay accessible
// [RULE_19] software reprograms clock rate code before resuming after power down
// [RULE_20] control port stays operational in every reduced power mode
// [RULE_21] clock select picks bit clock or pll; cleared on reset, sleep, power down
// [RULE_22] lock flag reads 1 while pll locked, zero after reset
// [RULE_23] line copies 0x12-0x18 are write-only shadows checked by polling
// [RULE_24] read-only registers ignore writes and still return their value
// [RULE_25] poll request writes are ignored while a poll is in progress
// [RULE_26] interrupt sources are sticky so events during a read are kept
`timescale 1ns/10ps
`include "hscp_defs.svh"
module hscp_core
    import hscp_pkg::*;
#(
    parameter int          POLL_TIMEOUT = `HSCP_POLL_CYCLES,
    parameter logic [3:0]  HOST_REV     = 4'h3,   // arbitrary value
    parameter logic [3:0]  LINE_REV     = 4'ha    // arbitrary value
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire hscp_req_t     req_in,
    output logic [7:0]         rdata_out,
    output logic               rvalid_out,
    output hscp_brd_t          brd_out,
    input  wire logic          brd_ack_in,
    input  wire logic [7:0]    brd_data_in,
    input  wire logic          barrier_sync_in,
    input  wire logic          pll_locked_in,
    input  wire logic [4:0]    event_in,
    input  wire logic [2:0]    gpio_edge_in,
    output logic               irq_n_out,
    output logic               front_end_on_out,
    output logic               pll_run_out,
    output logic               clk_sel_pll_out,
    output logic               pcm_out_tristate_out,
    output logic               core_shutdown_out
);
    logic [7:0]  irq_src_ff;
    logic [7:0]  irq_en_ff;
    logic [2:0]  gpio_dir_ff;
    logic [2:0]  power_ff;       // {front_end_enable, power_down_enable, sleep_enable}
    logic        clk_sel_ff;
    logic        lock_ff;
    logic [7:0]  shadow_ff [7];
    logic [3:0]  poll_index_ff;
    logic        poll_request_ff;
    logic        poll_match_ff;
    logic [7:0]  poll_value_ff;
    hscp_state_t state_ff;
    logic [15:0] timer_ff;
    logic [7:0]  nxt_rdata;
    logic [7:0]  live_src;
    logic        wr_any;
    logic        rd_src;
    logic        low_power;
    logic        poll_start;

    assign wr_any     = req_in.wr;
    assign rd_src     = req_in.rd && req_in.addr == `HSCP_OFF_IRQ_SRC;
    assign low_power  = power_ff[1] || power_ff[0];
    // a start needs an idle engine, a pollable index and a live front end
    assign poll_start = wr_any && req_in.addr == `HSCP_OFF_POLL_CTRL
                        && req_in.wdata[`HSCP_BIT_POLL] && state_ff == HSCP_IDLE   // RULE_25
                        && req_in.wdata[3:0] <= `HSCP_IDX_LAST && power_ff[2];      // RULE_02

    // gpio events only from pins set as inputs, other sources direct
    assign live_src = {gpio_edge_in & gpio_dir_ff, event_in};   // RULE_12

    // sticky interrupt source, cleared by read; set wins over clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_src_ff <= `HSCP_IRQ_SRC_RST;   // RULE_14
        end else if (rd_src) begin
            irq_src_ff <= live_src;             // RULE_13 RULE_26
        end else begin
            irq_src_ff <= irq_src_ff | live_src;   // RULE_26
        end
    end

    // interrupt output: or of enabled sources, registered, active low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= ~|(irq_src_ff & irq_en_ff & {gpio_dir_ff, 5'h1f});   // RULE_11 RULE_12
        end
    end

    // writable host registers; still live in low power
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_en_ff   <= `HSCP_IRQ_EN_RST;
            gpio_dir_ff <= `HSCP_GPIO_DIR_RST;
            power_ff    <= `HSCP_POWER_RST;
        end else if (wr_any) begin   // RULE_20
            unique case (req_in.addr)
                `HSCP_OFF_IRQ_EN:   irq_en_ff   <= req_in.wdata;
                `HSCP_OFF_REV_GPIO: gpio_dir_ff <= req_in.wdata[7:5];   // RULE_09 low nibble ignored
                `HSCP_OFF_POWER:    power_ff    <= req_in.wdata[`HSCP_BIT_FE_EN:`HSCP_BIT_SLEEP];
                default: ;
            endcase
        end
    end

    // clock select: cleared on entering sleep or power down
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_sel_ff <= 1'b0;
        end else if (low_power) begin
            clk_sel_ff <= 1'b0;   // RULE_21
        end else if (wr_any && req_in.addr == `HSCP_OFF_CLK_SEL) begin
            clk_sel_ff <= req_in.wdata[`HSCP_BIT_CLK_SEL];   // RULE_21
        end
    end

    // pll lock status capture; pll counted unlocked while stopped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            lock_ff <= 1'b0;
        end else begin
            lock_ff <= pll_locked_in && !low_power;   // RULE_22
        end
    end

    // line side shadows, one per pollable register
    for (genvar i = 0; i < 7; i++) begin : g_shadow
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                shadow_ff[i] <= 8'h00;
            end else if (wr_any && req_in.addr == `HSCP_OFF_LINE_FIRST + 5'(i)) begin
                shadow_ff[i] <= req_in.wdata;   // RULE_23
            end
        end
    end

    // poll index register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            poll_index_ff <= 4'h0;
        end else if (wr_any && req_in.addr == `HSCP_OFF_POLL_CTRL && state_ff == HSCP_IDLE) begin
            poll_index_ff <= req_in.wdata[3:0];   // RULE_02
        end
    end

    // poll engine: issue, wait for the line side answer, publish
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff        <= HSCP_IDLE;
            poll_request_ff <= 1'b0;
            brd_out         <= '0;
            timer_ff        <= 16'h0000;
        end else begin
            unique case (state_ff)
                HSCP_IDLE: begin
                    if (poll_start) begin
                        state_ff        <= HSCP_WAIT;
                        poll_request_ff <= 1'b1;                                 // RULE_06
                        brd_out         <= '{valid: 1'b1, index: req_in.wdata[3:0]};   // RULE_03
                        timer_ff        <= 16'h0000;
                    end
                end
                HSCP_WAIT: begin
                    brd_out.valid <= 1'b0;
                    timer_ff      <= timer_ff + 16'h0001;
                    // answer, lost front end or timeout all end the poll
                    if (brd_ack_in || !power_ff[2] || timer_ff == 16'(POLL_TIMEOUT - 1)) begin
                        state_ff <= HSCP_DONE;
                    end
                end
                HSCP_DONE: begin
                    state_ff        <= HSCP_IDLE;
                    poll_request_ff <= 1'b0;   // RULE_06
                end
            endcase
        end
    end

    // result capture: value and compare with shadow
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            poll_value_ff <= 8'h00;
            poll_match_ff <= 1'b0;
        end else if (state_ff == HSCP_WAIT && brd_ack_in) begin
            poll_value_ff <= brd_data_in;                                        // RULE_04
            poll_match_ff <= brd_data_in == shadow_ff[poll_index_ff[2:0]];        // RULE_05
        end
    end

    // read mux; read-only fields return state, shadows read zero
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (req_in.addr)
            `HSCP_OFF_IRQ_SRC:   nxt_rdata = irq_src_ff;
            `HSCP_OFF_REV_GPIO:  nxt_rdata = {gpio_dir_ff, 1'b0, HOST_REV};                  // RULE_09
            `HSCP_OFF_IRQ_EN:    nxt_rdata = irq_en_ff;
            `HSCP_OFF_LOCK:      nxt_rdata = {lock_ff, 7'h00};                               // RULE_22 RULE_24
            `HSCP_OFF_CLK_SEL:   nxt_rdata = {clk_sel_ff, 7'h00};
            `HSCP_OFF_POWER:     nxt_rdata = {power_ff, 5'h00};
            `HSCP_OFF_POLL_CTRL: nxt_rdata = {poll_request_ff, poll_match_ff, 2'b00, poll_index_ff};
            `HSCP_OFF_LINE_REV:  nxt_rdata = {barrier_sync_in ? LINE_REV : 4'h0, 4'h0};      // RULE_10
            `HSCP_OFF_POLL_VAL:  nxt_rdata = poll_value_ff;                                  // RULE_01
            default:             nxt_rdata = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the request
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
        end else begin
            rdata_out  <= req_in.rd ? nxt_rdata : 8'h00;
            rvalid_out <= req_in.rd;
        end
    end

    // power mode outputs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            front_end_on_out     <= 1'b1;
            pll_run_out          <= 1'b1;
            clk_sel_pll_out      <= 1'b0;
            pcm_out_tristate_out <= 1'b0;
            core_shutdown_out    <= 1'b0;
        end else begin
            front_end_on_out     <= power_ff[2] && !power_ff[1];         // RULE_16 RULE_18
            pll_run_out          <= !low_power;                          // RULE_17
            clk_sel_pll_out      <= clk_sel_ff && lock_ff && !low_power; // RULE_17 RULE_21
            pcm_out_tristate_out <= low_power;                           // RULE_17
            core_shutdown_out    <= power_ff[1];                         // RULE_18
        end
    end

    // checks
    sequence s_poll_issue;
        poll_start ##1 (poll_request_ff && brd_out.valid);
    endsequence
    sequence s_poll_finish;
        (state_ff == HSCP_DONE) ##1 (!poll_request_ff && state_ff == HSCP_IDLE);
    endsequence

    // a start raises the request bit and one read
    a_poll_issue: assert property (@(posedge clk_in) disable iff (rst_in) poll_start |-> s_poll_issue)   // RULE_03
        else $error("poll did not issue barrier read");

    // request bit stands through the wait
    a_poll_held: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == HSCP_WAIT) |-> poll_request_ff)   // RULE_06
        else $error("poll request dropped early");

    // answer lands, then request bit falls
    a_value_store: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == HSCP_WAIT && brd_ack_in) |=> (poll_value_ff == $past(brd_data_in)) ##1 !poll_request_ff)   // RULE_04
        else $error("poll value not stored");

    // mismatch leaves the flag low
    a_match_eq: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff == HSCP_WAIT && brd_ack_in && brd_data_in != shadow_ff[poll_index_ff[2:0]]) |=> !poll_match_ff)   // RULE_05
        else $error("match set on mismatch");

    // only one barrier read in flight
    a_no_restart: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_ff != HSCP_IDLE) |-> !brd_out.valid || $rose(poll_request_ff))   // RULE_25
        else $error("second barrier read while busy");

    // ring events on source bit 0 are kept until read
    a_irq_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        (!rd_src && event_in[0]) |=> irq_src_ff[0])   // RULE_26
        else $error("ring event lost");

    // any enabled line source pulls the pin low
    a_irq_or: assert property (@(posedge clk_in) disable iff (rst_in)
        |(irq_src_ff[4:0] & irq_en_ff[4:0]) |=> !irq_n_out)   // RULE_11
        else $error("enabled source did not assert interrupt");

    // low power forces the bit clock
    a_clksel_clr: assert property (@(posedge clk_in) disable iff (rst_in) low_power |=> !clk_sel_ff)   // RULE_21
        else $error("clock select not cleared in low power");

    // no revision without sync
    a_rev_sync: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_in.rd && req_in.addr == `HSCP_OFF_LINE_REV && !barrier_sync_in) |=> rdata_out == 8'h00)   // RULE_10
        else $error("line revision shown without sync");

    // revision shown with sync
    a_rev_show: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_10
        (req_in.rd && req_in.addr == `HSCP_OFF_LINE_REV && barrier_sync_in) |=> rdata_out == {LINE_REV, 4'h0})
        else $error("line revision missing with sync");

    // done drops the request bit and idles
    a_poll_done: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_06
        (state_ff == HSCP_DONE) |-> s_poll_finish)
        else $error("poll did not finish");

    // equal answer sets the flag
    a_match_set: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_05
        (state_ff == HSCP_WAIT && brd_ack_in && brd_data_in == shadow_ff[poll_index_ff[2:0]]) |=> poll_match_ff)
        else $error("match clear on equal value");

    // out of range index issues nothing
    a_index_refuse: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_02
        (wr_any && req_in.addr == `HSCP_OFF_POLL_CTRL && req_in.wdata[3:0] > `HSCP_IDX_LAST) |=> !brd_out.valid)
        else $error("read issued for bad index");

    // front end off issues nothing
    a_fe_refuse: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_16
        (wr_any && req_in.addr == `HSCP_OFF_POLL_CTRL && !power_ff[2]) |=> !brd_out.valid)
        else $error("read issued with front end off");

    // value moves only on an answer
    a_value_hold: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_04
        !(state_ff == HSCP_WAIT && brd_ack_in) |=> $stable(poll_value_ff))
        else $error("poll value moved without answer");

    // writes to the value register ignored
    a_ro_write: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_24
        (wr_any && req_in.addr == `HSCP_OFF_POLL_VAL && state_ff != HSCP_WAIT) |=> $stable(poll_value_ff))
        else $error("read-only value written");

    // read with no new event clears all
    a_rd_clear: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_13
        (rd_src && !(|live_src)) |=> irq_src_ff == 8'h00)
        else $error("source register not cleared");

    // no enabled input source keeps the pin high
    a_irq_quiet: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_12
        !(|(irq_src_ff & irq_en_ff & {gpio_dir_ff, 5'h1f})) |=> irq_n_out)
        else $error("interrupt without enabled source");

    // every read is answered
    a_rd_answer: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_20
        req_in.rd |=> rvalid_out)
        else $error("read not answered");

    // low power stops pll and floats pcm outputs
    a_low_out: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_17
        low_power |=> !pll_run_out && pcm_out_tristate_out)
        else $error("low power outputs wrong");

    // power down shuts the core and the front end
    a_shut_down: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_18
        power_ff[1] |=> core_shutdown_out && !front_end_on_out)
        else $error("power down not applied");

    // unlocked pll reads unlocked
    a_lock_flag: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_22
        !pll_locked_in |=> !lock_ff)
        else $error("lock flag without lock");

    // barrier read is a single pulse
    a_brd_pulse: assert property (@(posedge clk_in) disable iff (rst_in)   // RULE_03
        brd_out.valid |=> !brd_out.valid)
        else $error("barrier read held too long");
endmodule

// *** core/hscp_defs.svh ***
// constants for the host side control and poll block: offsets, fields, resets, timing
// assumes inclusion by the package and the core module only
`ifndef HSCP_DEFS_SVH
`define HSCP_DEFS_SVH
`define HSCP_AW              5
`define HSCP_OFF_IRQ_SRC     5'h03
`define HSCP_OFF_REV_GPIO    5'h04
`define HSCP_OFF_IRQ_EN      5'h05
`define HSCP_OFF_LOCK        5'h0d
`define HSCP_OFF_CLK_SEL     5'h0e
`define HSCP_OFF_POWER       5'h0f
`define HSCP_OFF_HOST_LAST   5'h10
`define HSCP_OFF_LINE_FIRST  5'h12
`define HSCP_OFF_LINE_LAST   5'h18
`define HSCP_OFF_POLL_CTRL   5'h19
`define HSCP_OFF_LINE_REV    5'h1d
`define HSCP_OFF_POLL_VAL    5'h1f
`define HSCP_OFF_HI_FIRST    5'h20
`define HSCP_IDX_LAST        4'h6
`define HSCP_BIT_POLL        7
`define HSCP_BIT_MATCH       6
`define HSCP_BIT_FE_EN       7
`define HSCP_BIT_POWER_DOWN_ENABLE        6
`define HSCP_BIT_SLEEP       5
`define HSCP_BIT_CLK_SEL     7
`define HSCP_BIT_LOCK        7
`define HSCP_IRQ_SRC_RST     8'he0
`define HSCP_IRQ_EN_RST      8'h00
`define HSCP_POWER_RST       3'h4
`define HSCP_GPIO_DIR_RST    3'h7
`define HSCP_POLL_TIME_US    600
`define HSCP_CLK_MHZ         10
`define HSCP_POLL_CYCLES     (`HSCP_POLL_TIME_US * `HSCP_CLK_MHZ)
`endif

// *** core/hscp_pkg.sv ***
// types for the host side control and poll block
// assumes the defines header is on the include path
`include "hscp_defs.svh"
package hscp_pkg;
    // register access request from the serial control port
    typedef struct packed {
        logic                 wr;
        logic                 rd;
        logic [`HSCP_AW-1:0]  addr;
        logic [7:0]           wdata;
    } hscp_req_t;
    // barrier read request toward the line side
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
    } hscp_brd_t;
    // poll engine states
    typedef enum logic [2:0] {
        HSCP_IDLE = 3'b001,
        HSCP_WAIT = 3'b010,
        HSCP_DONE = 3'b100
    } hscp_state_t;
endpackage

// *** dv/hscp_line_model.sv ***
// line-side device model: answers each barrier index read with one data strobe
// assumes the bench sets answer delay and a corruption mask between polls
`timescale 1ns/10ps
module hscp_line_model
    import hscp_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire hscp_brd_t   brd_in,
    input  wire logic [7:0]  wait_in,
    input  wire logic [7:0]  flip_in,
    output logic             ack_out,
    output logic [7:0]       data_out,
    output logic [7:0]       reads_out
);
    logic       busy_ff;
    logic [7:0] cnt_ff;
    logic [3:0] idx_ff;
    // one read in flight; data toggles when not acked so stale values never look valid
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_ff   <= 1'b0;
            cnt_ff    <= 8'h00;
            idx_ff    <= 4'h0;
            ack_out   <= 1'b0;
            data_out  <= 8'h00;
            reads_out <= 8'h00;
        end else begin
            ack_out  <= 1'b0;
            data_out <= ~data_out;
            if (brd_in.valid) begin
                busy_ff   <= 1'b1;
                cnt_ff    <= wait_in;
                idx_ff    <= brd_in.index;
                reads_out <= reads_out + 8'h01;
            end else if (busy_ff && cnt_ff == 8'h00) begin
                busy_ff  <= 1'b0;
                ack_out  <= 1'b1;
                data_out <= {4'h5, idx_ff} ^ flip_in;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end
endmodule

// *** dv/hscp_tb.sv ***
// self-checking bench for the host side control and poll block
// assumes the line model on the barrier side and a 10 MHz clock
`timescale 1ns/10ps
module testbench;
    import hscp_pkg::*;
    localparam logic [3:0] HREV = 4'h3;   // arbitrary value
    localparam logic [3:0] LREV = 4'ha;   // arbitrary value
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    hscp_req_t  req = '0;
    hscp_brd_t  brd;
    logic [7:0] rdata, bdata, reads, d, r0;
    logic [7:0] wt = 8'h00, flip = 8'h00, v;
    logic       rvalid, ack, irq_n, fe, pll, csel, tri_s, shut;
    logic       sync = 1'b0, lock = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [2:0] ge = 3'h0;
    int         failures = 0, compares = 0, cycles = 0;
    // clock and hang guard
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end
    hscp_core #(.POLL_TIMEOUT(20), .HOST_REV(HREV), .LINE_REV(LREV)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
        .brd_out(brd), .brd_ack_in(ack), .brd_data_in(bdata), .barrier_sync_in(sync),
        .pll_locked_in(lock), .event_in(ev), .gpio_edge_in(ge), .irq_n_out(irq_n),
        .front_end_on_out(fe), .pll_run_out(pll), .clk_sel_pll_out(csel),
        .pcm_out_tristate_out(tri_s), .core_shutdown_out(shut));
    hscp_line_model line (
        .clk_in(clk_in), .rst_in(rst_in), .brd_in(brd), .wait_in(wt), .flip_in(flip),
        .ack_out(ack), .data_out(bdata), .reads_out(reads));
    task automatic print_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] x);
        @(posedge clk_in);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: x};
        @(posedge clk_in);
        req <= '0;
    endtask
    // read answers one cycle after the request is taken
    task automatic rd(input logic [4:0] a, output logic [7:0] x);
        @(posedge clk_in);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        req <= '0;
        #1;
        x = (rvalid === 1'b1) ? rdata : 8'hxx;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a, d);
        chk(d & m, e);
    endtask
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_done;
        int k;
        for (k = 0; k < 40 && d[7] !== 1'b0; k++) rd(5'h19, d);
        chk(d & 8'h80, 8'h00);
    endtask
    task automatic pulse(input logic [7:0] x);
        @(posedge clk_in);
        ev <= x[4:0];
        ge <= x[7:5];
        @(posedge clk_in);
        ev <= 5'h00;
        ge <= 3'h0;
        settle();
    endtask
    task automatic t_reset;
        rchk(5'h03, 8'hff, 8'he0);
        rchk(5'h03, 8'hff, 8'h00);
        rchk(5'h04, 8'h0f, {4'h0, HREV});
        rchk(5'h0d, 8'h80, 8'h00);
        rchk(5'h0e, 8'h80, 8'h00);
        rchk(5'h0f, 8'he0, 8'h80);
        rchk(5'h19, 8'hcf, 8'h00);
        rchk(5'h1f, 8'hff, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        wr(5'h1f, 8'hff);
        wr(5'h0d, 8'hff);
        wr(5'h04, 8'hef);
        rchk(5'h1f, 8'hff, 8'h00);
        rchk(5'h0d, 8'h80, 8'h00);
        rchk(5'h04, 8'h0f, {4'h0, HREV});
        rchk(5'h11, 8'hff, 8'h00);
        rchk(5'h1d, 8'hf0, 8'h00);
        @(posedge clk_in);
        sync <= 1'b1;
        lock <= 1'b1;
        rchk(5'h1d, 8'hf0, {LREV, 4'h0});
        rchk(5'h0d, 8'h80, 8'h80);
    endtask
    // poll every index against a matching shadow
    task automatic t_poll_all;
        int n;
        for (n = 0; n < 7; n++) begin
            wr(5'h12 + 5'(n), {4'h5, 4'(n)});
            wt <= 8'(n);
            wr(5'h19, {4'h8, 4'(n)});
            #1;
            chk({3'h0, brd.valid, brd.index}, {4'h1, 4'(n)});
            rchk(5'h19, 8'h80, 8'h80);
            wait_done();
            rchk(5'h1f, 8'hff, {4'h5, 4'(n)});
            rchk(5'h19, 8'h40, 8'h40);
        end
        rchk(5'h12, 8'hff, 8'h00);
        wr(5'h19, 8'h00);
    endtask
    // corrupted answer, slow, with a second request while busy
    task automatic t_poll_busy;
        flip <= 8'h0f;
        wt <= 8'd10;
        r0 = reads;
        wr(5'h19, 8'h81);
        wr(5'h19, 8'h85);
        d = 8'h80;
        wait_done();
        rchk(5'h19, 8'hff, 8'h01);
        chk(reads, r0 + 8'h01);
        rchk(5'h1f, 8'hff, 8'h5e);
        wr(5'h19, 8'h87);
        #1;
        chk({7'h0, brd.valid}, 8'h00);
        rchk(5'h19, 8'h80, 8'h00);
        wr(5'h0f, 8'h00);
        wr(5'h19, 8'h82);
        settle();
        chk({7'h0, fe}, 8'h00);
        rchk(5'h19, 8'h80, 8'h00);
        chk(reads, r0 + 8'h01);
        wr(5'h0f, 8'h80);
    endtask
    task automatic t_irq;
        int i;
        wr(5'h05, 8'hff);
        for (i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            pulse(v);
            chk({7'h0, irq_n}, 8'h00);
            rchk(5'h03, 8'hff, v);
            settle();
            chk({7'h0, irq_n}, 8'h01);
        end
        wr(5'h05, 8'hfb);
        pulse(8'h04);
        chk({7'h0, irq_n}, 8'h01);
        rd(5'h03, d);
        wr(5'h05, 8'hff);
        wr(5'h04, 8'h00);
        pulse(8'he0);
        chk({7'h0, irq_n}, 8'h01);
        rd(5'h03, d);
        wr(5'h04, 8'he0);
        @(posedge clk_in);
        ev <= 5'h01;
        req <= '{wr: 1'b0, rd: 1'b1, addr: 5'h03, wdata: 8'h00};
        @(posedge clk_in);
        ev <= 5'h00;
        req <= '0;
        #1;
        chk(rdata, 8'h00);
        rchk(5'h03, 8'hff, 8'h01);
    endtask
    task automatic t_power;
        wr(5'h0e, 8'h80);
        settle();
        chk({7'h0, csel}, 8'h01);
        wr(5'h0f, 8'ha0);
        settle();
        chk({5'h0, pll, tri_s, csel}, 8'h02);
        rchk(5'h0e, 8'h80, 8'h00);
        rchk(5'h05, 8'hff, 8'hff);
        pulse(8'h01);
        chk({7'h0, irq_n}, 8'h00);
        rd(5'h03, d);
        wr(5'h0f, 8'hc0);
        settle();
        chk({7'h0, shut}, 8'h01);
        rchk(5'h0f, 8'he0, 8'hc0);
        wr(5'h0f, 8'h80);
        wr(5'h23, 8'h20);
        settle();
        chk({5'h0, shut, pll, tri_s}, 8'h02);
    endtask
    // line side never answers in time: old results stay
    task automatic t_timeout;
        wt <= 8'd60;
        flip <= 8'h00;
        wr(5'h19, 8'h82);
        d = 8'h80;
        wait_done();
        rchk(5'h1f, 8'hff, 8'h5e);
    endtask
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_poll_all();
        t_poll_busy();
        t_irq();
        t_power();
        t_timeout();
        print_verdict();
    end
endmodule
